/* core/flash_seq_cfg.svh */
`ifndef FLASH_SEQ_CFG_SVH
`define FLASH_SEQ_CFG_SVH
// Notes on behaviour
// - Programming never erases; it only writes latched data into the row.
// - Erase always covers a whole row, never a single word.
// - One programming operation writes at most the 32 latches.
// - Upper 11 address bits pick the row; address bits 3:0 pick the latch.
// - Programming touches only the addressed row, never crossing its boundary.
// - Every latch returns to 0x3FFF when any program or erase completes.
// - Unloaded latches stay blank so partial rows may be programmed.
// - Latch-only set, free clear: unlock then write-start loads the addressed latch only.
// - Latch-only clear, free clear: load the latch then program all latches into the row.
// - A broken unlock sequence starts neither latch load nor programming.
// - A latch-only start forces two idle cycles, then no stall.
// - A row start stalls the core until done, resuming at the third instruction.
// - Software only sets write-start; the device clears it when done.
// - With program-erase enable clear, every program and erase is blocked.
// - Config-space select clear targets main program flash.

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define FS_ADDR_LOW_OFS     4'h0
`define FS_ADDR_HIGH_OFS    4'h1
`define FS_DATA_LOW_OFS     4'h2
`define FS_DATA_HIGH_OFS    4'h3
`define FS_CONTROL_OFS      4'h4
`define FS_UNLOCK_KEY_OFS   4'h5

// ----------------------------------------
// Control bit positions
// ----------------------------------------
`define FS_BIT_RD           0
`define FS_BIT_WR           1
`define FS_BIT_PROGRAM_ERASE_ENABLE         2
`define FS_BIT_WRERR        3
`define FS_BIT_FREE         4
`define FS_BIT_LATCH_ONLY_LOAD         5
`define FS_BIT_CONFIG_SPACE_SELECT         6

// ----------------------------------------
// Values
// ----------------------------------------
`define FS_KEY_FIRST        8'h55
`define FS_KEY_SECOND       8'hAA
`define FS_BLANK_WORD       14'h3FFF
`define FS_LATCH_COUNT      32
`define FS_FORCED_IDLE      2
`define FS_PROG_TIME_NS     2000000
`define FS_CLK_PERIOD_NS    4
`define FS_PROG_CYCLES      (`FS_PROG_TIME_NS / `FS_CLK_PERIOD_NS)
`endif

/* core/flash_seq_pkg.sv */
package flash_seq_pkg;
	typedef enum {
		SEQ_IDLE,
		SEQ_KEY1,
		SEQ_KEY2
	} unlock_state_t;

	typedef enum {
		OP_IDLE,
		OP_FORCE_IDLE,
		OP_BUSY
	} op_state_t;

	typedef struct packed {
		logic [3:0] addr;
		logic [7:0] wdata;
		logic       wr;
		logic       rd;
	} reg_req_t;

	typedef struct packed {
		logic        valid;
		logic        erase;
		logic        config_space;
		logic [14:0] addr;
		logic [13:0] data;
	} flash_op_t;
endpackage

/* core/flash_latch_bank.sv */
`timescale 1ns/1ns
`include "flash_seq_cfg.svh"

module flash_latch_bank #(
	parameter int LATCHES = `FS_LATCH_COUNT,
	parameter int WIDTH   = 14
) (
	input  wire logic                       core_clk_i,
	input  wire logic                       rst_i,
	input  wire logic                       load_i,
	input  wire logic [$clog2(LATCHES)-1:0] index_i,
	input  wire logic [WIDTH-1:0]           data_i,
	input  wire logic                       blank_i,
	output logic [LATCHES*WIDTH-1:0]        row_o
);
	logic [WIDTH-1:0] latch_reg [LATCHES];

	// ----------------------------------------
	// Latch array
	// ----------------------------------------
	// Blanking wins over a load in the same cycle; both cannot meet while busy
	always_ff @(posedge core_clk_i) begin
		for (int i = 0; i < LATCHES; i++) begin
			if (rst_i || blank_i) begin
				latch_reg[i] <= WIDTH'(`FS_BLANK_WORD);
			end else if (load_i && index_i == i[$clog2(LATCHES)-1:0]) begin
				latch_reg[i] <= data_i;
			end
		end
	end

	always_comb begin
		for (int i = 0; i < LATCHES; i++) begin
			row_o[i*WIDTH +: WIDTH] = latch_reg[i];
		end
	end
endmodule

/* core/flash_row_write_latch_sequencer.sv */
`timescale 1ns/1ns
`include "flash_seq_cfg.svh"

module flash_row_write_latch_sequencer #(
	parameter int LATCHES     = `FS_LATCH_COUNT,
	parameter int PROG_CYCLES = `FS_PROG_CYCLES
) (
	input  wire logic                  core_clk_i,
	input  wire logic                  rst_i,
	input  wire logic [3:0]            reg_addr_i,
	input  wire logic [7:0]            reg_wdata_i,
	input  wire logic                  reg_wr_i,
	input  wire logic                  reg_rd_i,
	output logic [7:0]                 reg_rdata_o,
	output logic                       core_stall_o,
	output logic                       core_force_idle_o,
	output logic                       flash_prog_o,
	output logic                       flash_erase_o,
	output logic                       flash_config_space_o,
	output logic [10:0]                flash_row_o,
	output logic [LATCHES*14-1:0]      flash_row_data_o
);
	localparam int IDX_W = $clog2(LATCHES);
	localparam int CNT_W = $clog2(PROG_CYCLES + 1);

	// ----------------------------------------
	// Registers
	// ----------------------------------------
	flash_seq_pkg::reg_req_t      req;
	flash_seq_pkg::unlock_state_t unlock_reg;
	flash_seq_pkg::unlock_state_t unlock_next;
	flash_seq_pkg::op_state_t     op_reg;
	flash_seq_pkg::op_state_t     op_next;
	flash_seq_pkg::flash_op_t     op_launch;

	logic [7:0]       addr_low_reg;
	logic [6:0]       addr_high_reg;
	logic [7:0]       data_low_reg;
	logic [5:0]       data_high_reg;
	logic             config_space_select_reg;
	logic             latch_only_load_reg;
	logic             free_reg;
	logic             wrerr_reg;
	logic             program_erase_enable_reg;
	logic             wr_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic [CNT_W-1:0] cnt_next;
	logic             latch_only_op_reg;
	logic [7:0]       reg_rdata_reg;
	logic             stall_reg;
	logic             force_idle_reg;
	logic             prog_reg;
	logic             erase_reg;
	logic             cfg_out_reg;
	logic [10:0]      row_reg;

	// ----------------------------------------
	// Decode
	// ----------------------------------------
	function automatic logic hit(input logic [3:0] a, input logic [3:0] ofs);
		return a == ofs;
	endfunction

	assign req.addr  = reg_addr_i;
	assign req.wdata = reg_wdata_i;
	assign req.wr    = reg_wr_i;
	assign req.rd    = reg_rd_i;

	wire wr_addr_low  = req.wr && hit(req.addr, `FS_ADDR_LOW_OFS);
	wire wr_addr_high = req.wr && hit(req.addr, `FS_ADDR_HIGH_OFS);
	wire wr_data_low  = req.wr && hit(req.addr, `FS_DATA_LOW_OFS);
	wire wr_data_high = req.wr && hit(req.addr, `FS_DATA_HIGH_OFS);
	wire wr_control   = req.wr && hit(req.addr, `FS_CONTROL_OFS);
	wire wr_key       = req.wr && hit(req.addr, `FS_UNLOCK_KEY_OFS);
	wire busy         = op_reg != flash_seq_pkg::OP_IDLE;

	// A write-start attempt; only honoured straight after both keys
	wire start_try  = wr_control && req.wdata[`FS_BIT_WR] && !busy;
	wire unlocked   = unlock_reg == flash_seq_pkg::SEQ_KEY2;
	wire start_ok   = start_try && unlocked && program_erase_enable_reg;
	wire ctrl_latch_only_load  = req.wdata[`FS_BIT_LATCH_ONLY_LOAD];
	wire ctrl_free  = req.wdata[`FS_BIT_FREE];
	wire ctrl_config_space_select  = req.wdata[`FS_BIT_CONFIG_SPACE_SELECT];

	// Mode comes from the same write that sets write-start
	wire latch_only = ctrl_latch_only_load && !ctrl_free;
	wire do_load    = start_ok && !ctrl_free;
	wire do_row     = start_ok && !latch_only;

	assign op_launch.valid        = do_row;
	assign op_launch.erase        = ctrl_free;
	assign op_launch.config_space = ctrl_config_space_select;
	assign op_launch.addr         = {addr_high_reg, addr_low_reg};
	assign op_launch.data         = {data_high_reg, data_low_reg};

	wire [IDX_W-1:0] latch_idx = IDX_W'(addr_low_reg[3:0]);
	wire             op_done   = op_reg == flash_seq_pkg::OP_BUSY
	                             && cnt_reg == '0;

	// ----------------------------------------
	// Unlock tracker
	// ----------------------------------------
	// Any other register write between keys breaks the sequence
	always_comb begin
		unlock_next = unlock_reg;
		if (req.wr) begin
			if (wr_key && req.wdata == `FS_KEY_FIRST) begin
				unlock_next = flash_seq_pkg::SEQ_KEY1;
			end else if (wr_key && req.wdata == `FS_KEY_SECOND
			             && unlock_reg == flash_seq_pkg::SEQ_KEY1) begin
				unlock_next = flash_seq_pkg::SEQ_KEY2;
			end else begin
				unlock_next = flash_seq_pkg::SEQ_IDLE;
			end
		end
	end

	// ----------------------------------------
	// Operation sequencer
	// ----------------------------------------
	always_comb begin
		op_next  = op_reg;
		cnt_next = cnt_reg;
		case (op_reg)
			flash_seq_pkg::OP_IDLE: begin
				if (start_ok) begin
					op_next  = flash_seq_pkg::OP_FORCE_IDLE;
					cnt_next = CNT_W'(`FS_FORCED_IDLE - 1);
				end
			end
			flash_seq_pkg::OP_FORCE_IDLE: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else if (latch_only_op_reg) begin
					op_next = flash_seq_pkg::OP_IDLE;
				end else begin
					op_next  = flash_seq_pkg::OP_BUSY;
					cnt_next = CNT_W'(PROG_CYCLES - 1);
				end
			end
			flash_seq_pkg::OP_BUSY: begin
				if (cnt_reg != '0) begin
					cnt_next = cnt_reg - 1'b1;
				end else begin
					op_next = flash_seq_pkg::OP_IDLE;
				end
			end
			default: begin
				op_next = flash_seq_pkg::OP_IDLE;
			end
		endcase
	end

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			unlock_reg        <= flash_seq_pkg::SEQ_IDLE;
			op_reg            <= flash_seq_pkg::OP_IDLE;
			cnt_reg           <= '0;
			latch_only_op_reg <= 1'b0;
		end else begin
			unlock_reg <= unlock_next;
			op_reg     <= op_next;
			cnt_reg    <= cnt_next;
			if (start_ok) begin
				latch_only_op_reg <= latch_only;
			end
		end
	end

	// ----------------------------------------
	// Software registers
	// ----------------------------------------
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			addr_low_reg  <= 8'h00;
			addr_high_reg <= 7'h00;
			data_low_reg  <= 8'h00;
			data_high_reg <= 6'h00;
		end else begin
			if (wr_addr_low) begin
				addr_low_reg <= req.wdata;
			end
			if (wr_addr_high) begin
				addr_high_reg <= req.wdata[6:0];
			end
			if (wr_data_low) begin
				data_low_reg <= req.wdata;
			end
			if (wr_data_high) begin
				data_high_reg <= req.wdata[5:0];
			end
		end
	end

	// Control writes are ignored while an operation runs
	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			config_space_select_reg  <= 1'b0;
			latch_only_load_reg  <= 1'b0;
			free_reg  <= 1'b0;
			program_erase_enable_reg  <= 1'b0;
			wrerr_reg <= 1'b0;
			wr_reg    <= 1'b0;
		end else if (wr_control && !busy) begin
			config_space_select_reg  <= ctrl_config_space_select;
			latch_only_load_reg  <= ctrl_latch_only_load;
			free_reg  <= ctrl_free;
			program_erase_enable_reg  <= req.wdata[`FS_BIT_PROGRAM_ERASE_ENABLE];
			wrerr_reg <= start_try ? !start_ok : req.wdata[`FS_BIT_WRERR];
			wr_reg    <= start_ok;
		end else if (op_next == flash_seq_pkg::OP_IDLE && busy) begin
			wr_reg   <= 1'b0;
			free_reg <= 1'b0;
		end
	end

	// ----------------------------------------
	// Latch bank
	// ----------------------------------------
	flash_latch_bank #(
		.LATCHES (LATCHES),
		.WIDTH   (14)
	) u_latches (
		.core_clk_i (core_clk_i),
		.rst_i      (rst_i),
		.load_i     (do_load),
		.index_i    (latch_idx),
		.data_i     (op_launch.data),
		.blank_i    (op_done),
		.row_o      (flash_row_data_o)
	);

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	wire [7:0] ctrl_read = {1'b1, config_space_select_reg, latch_only_load_reg, free_reg,
	                        wrerr_reg, program_erase_enable_reg, wr_reg, 1'b0};
	wire [7:0] rd_mux =
		hit(req.addr, `FS_ADDR_LOW_OFS)  ? addr_low_reg :
		hit(req.addr, `FS_ADDR_HIGH_OFS) ? {1'b1, addr_high_reg} :
		hit(req.addr, `FS_DATA_LOW_OFS)  ? data_low_reg :
		hit(req.addr, `FS_DATA_HIGH_OFS) ? {2'b00, data_high_reg} :
		hit(req.addr, `FS_CONTROL_OFS)   ? ctrl_read : 8'h00;

	always_ff @(posedge core_clk_i) begin
		if (rst_i) begin
			reg_rdata_reg  <= 8'h00;
			stall_reg      <= 1'b0;
			force_idle_reg <= 1'b0;
			prog_reg       <= 1'b0;
			erase_reg      <= 1'b0;
			cfg_out_reg    <= 1'b0;
			row_reg        <= 11'h000;
		end else begin
			reg_rdata_reg  <= req.rd ? rd_mux : 8'h00;
			force_idle_reg <= op_next == flash_seq_pkg::OP_FORCE_IDLE;
			stall_reg      <= op_next == flash_seq_pkg::OP_BUSY;
			prog_reg       <= op_next == flash_seq_pkg::OP_BUSY && !free_reg;
			erase_reg      <= op_next == flash_seq_pkg::OP_BUSY && free_reg;
			if (op_launch.valid) begin
				cfg_out_reg <= op_launch.config_space;
				row_reg     <= op_launch.addr[14:4];
			end
		end
	end

	assign reg_rdata_o          = reg_rdata_reg;
	assign core_stall_o         = stall_reg;
	assign core_force_idle_o    = force_idle_reg;
	assign flash_prog_o         = prog_reg;
	assign flash_erase_o        = erase_reg;
	assign flash_config_space_o = cfg_out_reg;
	assign flash_row_o          = row_reg;
endmodule

/* sim/flash_seq_sva.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Sequencer port checks
// ----------------------------------------
module flash_seq_sva #(
	parameter int LATCHES     = 32,
	parameter int PROG_CYCLES = 8
) (
	input wire logic                  core_clk_i,
	input wire logic                  rst_i,
	input wire logic [3:0]            reg_addr_i,
	input wire logic [7:0]            reg_wdata_i,
	input wire logic                  reg_wr_i,
	input wire logic                  core_stall_o,
	input wire logic                  core_force_idle_o,
	input wire logic                  flash_prog_o,
	input wire logic                  flash_erase_o,
	input wire logic [10:0]           flash_row_o,
	input wire logic [LATCHES*14-1:0] flash_row_data_o
);
	default clocking dc @(posedge core_clk_i); endclocking
	default disable iff (rst_i);
	logic        en_reg;
	logic [31:0] cnt_reg;
	wire         ctl_w  = reg_wr_i && reg_addr_i == 4'h4 && !core_stall_o && !core_force_idle_o;
	wire         key1_w = reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i == 8'h55;
	wire         key2_w = reg_wr_i && reg_addr_i == 4'h5 && reg_wdata_i == 8'hAA;
	wire         lo_w   = reg_wdata_i[5];
	wire         er_w   = reg_wdata_i[4];
	// Busy writes are dropped, so only idle writes move the enable copy
	always_ff @(posedge core_clk_i) begin
		en_reg <= rst_i ? 1'b0 : (ctl_w ? reg_wdata_i[2] : en_reg);
		cnt_reg <= (rst_i || !core_stall_o) ? 32'h00000000 : cnt_reg + 32'h00000001;
	end
	sequence unlock_s;
		key1_w ##1 key2_w;
	endsequence
	sequence start_s;
		ctl_w && reg_wdata_i[1] && en_reg;
	endsequence
	sequence idle_two_s;
		core_force_idle_o[*2] ##1 !core_force_idle_o;
	endsequence
	chk_start_taken: assert property (unlock_s ##1 start_s |=> core_force_idle_o)
		else $error("accepted start gave no idle");
	chk_idle_two: assert property ($rose(core_force_idle_o) |-> idle_two_s)
		else $error("forced idle not two cycles");
	chk_start_keyed: assert property ($rose(core_force_idle_o) |->
		$past(key2_w, 2) && $past(key1_w, 3) && $past(en_reg)) else $error("start without unlock");
	chk_latch_only: assert property (
		$rose(core_force_idle_o) && $past(lo_w) && !$past(er_w) |-> ##2 !core_stall_o && !flash_prog_o)
		else $error("latch load stalled");
	chk_row_start: assert property (
		$rose(core_force_idle_o) && !$past(lo_w) && !$past(er_w) |-> ##2 core_stall_o && flash_prog_o)
		else $error("row program did not stall");
	chk_stall_len: assert property ($fell(core_stall_o) |-> cnt_reg == PROG_CYCLES)
		else $error("stall length wrong");
	chk_stall_max: assert property (core_stall_o |-> cnt_reg < PROG_CYCLES)
		else $error("stall too long");
	chk_blank_done: assert property (
		$fell(core_stall_o) |-> flash_row_data_o == {LATCHES{14'h3FFF}}) else $error("not blank");
	chk_row_hold: assert property (core_stall_o && $past(core_stall_o) |-> $stable(flash_row_o))
		else $error("row moved while busy");
	chk_op_busy: assert property (flash_prog_o || flash_erase_o |-> core_stall_o)
		else $error("flash op outside stall");
	chk_erase_start: assert property (
		$rose(core_force_idle_o) && $past(er_w) |-> ##2 core_stall_o && flash_erase_o && !flash_prog_o)
		else $error("erase did not stall");
	chk_start_refused: assert property (
		ctl_w && reg_wdata_i[1] && (!en_reg || !$past(key2_w)) |=> !core_force_idle_o)
		else $error("unkeyed start accepted");
endmodule

bind flash_row_write_latch_sequencer flash_seq_sva #(
	.LATCHES(LATCHES), .PROG_CYCLES(PROG_CYCLES)
) flash_seq_sva_inst (
	.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
	.reg_wdata_i(reg_wdata_i), .core_stall_o(core_stall_o), .flash_prog_o(flash_prog_o),
	.core_force_idle_o(core_force_idle_o), .flash_erase_o(flash_erase_o),
	.flash_row_o(flash_row_o), .flash_row_data_o(flash_row_data_o)
);

/* sim/flash_array_model.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Flash array: programming only clears bits
// ----------------------------------------
module flash_array_model #(
	parameter int LATCHES = 32
) (
	input wire logic                  core_clk_i,
	input wire logic                  prog_i,
	input wire logic                  erase_i,
	input wire logic [10:0]           row_i,
	input wire logic                  cfg_i,
	input wire logic [LATCHES*14-1:0] data_i
);
	logic [LATCHES*14-1:0] mem [int];
	logic                  prog_q  = 1'b0;
	logic                  erase_q = 1'b0;
	function automatic logic [LATCHES*14-1:0] peek(input logic [10:0] r);
		return mem.exists(r) ? mem[r] : '1;
	endfunction
	always @(posedge core_clk_i) begin
		prog_q <= prog_i;
		erase_q <= erase_i;
		// Config-space operations leave the main array alone
		if (erase_i && !erase_q && !cfg_i) begin
			mem[row_i] = '1;
		end
		if (prog_i && !prog_q && !cfg_i) begin
			mem[row_i] = peek(row_i) & data_i;
		end
	end
endmodule

/* sim/tb.sv */
`timescale 1ns/1ns
// ----------------------------------------
// Self-write sequencer bench
// ----------------------------------------
module tb;
	localparam int N = 32;
	localparam int W = N * 14;
	logic         core_clk_i = 1'b0;
	logic         rst_i = 1'b1;
	logic [3:0]   reg_addr_i = 4'h0;
	logic [7:0]   reg_wdata_i = 8'h00;
	logic         reg_wr_i = 1'b0;
	logic         reg_rd_i = 1'b0;
	logic [7:0]   reg_rdata_o;
	logic         core_stall_o, core_force_idle_o, flash_prog_o, flash_erase_o, flash_config_space_o;
	logic [10:0]  flash_row_o, row;
	logic [W-1:0] flash_row_data_o, emem;
	logic [31:0]  rng = 32'h00007EDE;
	logic [13:0]  lat [N];
	int           failures = 0;
	int           tests_run = 0;
	always #2 core_clk_i = ~core_clk_i;
	flash_row_write_latch_sequencer #(.PROG_CYCLES(8)) flash_row_write_latch_sequencer_inst (
		.core_clk_i(core_clk_i), .rst_i(rst_i), .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i),
		.reg_wdata_i(reg_wdata_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
		.core_stall_o(core_stall_o), .core_force_idle_o(core_force_idle_o),
		.flash_prog_o(flash_prog_o), .flash_erase_o(flash_erase_o), .flash_row_o(flash_row_o),
		.flash_config_space_o(flash_config_space_o), .flash_row_data_o(flash_row_data_o)
	);
	flash_array_model #(.LATCHES(N)) flash_array_model_inst (
		.core_clk_i(core_clk_i), .prog_i(flash_prog_o), .erase_i(flash_erase_o),
		.row_i(flash_row_o), .data_i(flash_row_data_o), .cfg_i(flash_config_space_o)
	);
	function automatic logic [31:0] xs(input logic [31:0] s);
		s = s ^ (s << 13);
		s = s ^ (s >> 17);
		return s ^ (s << 5);
	endfunction
	function automatic logic [W-1:0] exp_row();
		logic [W-1:0] r;
		for (int i = 0; i < N; i++) r[i*14+:14] = lat[i];
		return r;
	endfunction
	task automatic check(input logic [W-1:0] seen, input logic [W-1:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
			failures++;
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, failures);
		if (failures == 0 && tests_run > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	task automatic cyc(input logic w, input logic r, input logic [3:0] a, input logic [7:0] d);
		reg_wr_i <= w;
		reg_rd_i <= r;
		reg_addr_i <= a;
		reg_wdata_i <= d;
		@(posedge core_clk_i);
	endtask
	task automatic rd(input logic [3:0] a, input logic [7:0] exp);
		cyc(1'b0, 1'b1, a, 8'h00);
		reg_rd_i <= 1'b0;
		#1;
		check(reg_rdata_o, exp);
		@(posedge core_clk_i);
	endtask
	// Keys then the start write; brk slips a foreign write between the keys
	task automatic go(input logic [7:0] k1, input logic [7:0] k2, input logic [7:0] ctl, input bit brk);
		cyc(1'b1, 1'b0, 4'h5, k1);
		if (brk) cyc(1'b1, 1'b0, 4'h0, {row[3:0], 4'h0});
		cyc(1'b1, 1'b0, 4'h5, k2);
		cyc(1'b1, 1'b0, 4'h4, ctl);
		cyc(1'b0, 1'b0, 4'h4, 8'h00);
	endtask
	// Ends settled, off the clock edge
	task automatic wait_idle();
		int n;
		n = 0;
		#1;
		while ((core_stall_o !== 1'b0 || core_force_idle_o !== 1'b0) && n < 50) begin
			@(posedge core_clk_i);
			#1;
			n++;
		end
		failures += (n == 50);
		if (n == 50) test_done();
	endtask
	task automatic op(input logic [3:0] idx, input logic [13:0] d, input logic [7:0] ctl);
		cyc(1'b1, 1'b0, 4'h0, {row[3:0], idx});
		cyc(1'b1, 1'b0, 4'h2, d[7:0]);
		cyc(1'b1, 1'b0, 4'h3, {2'b00, d[13:8]});
		go(8'h55, 8'hAA, ctl, 1'b0);
		if (!ctl[4]) lat[idx] = d;
		if (!ctl[5] || ctl[4]) begin
			emem = ctl[6] ? emem : ctl[4] ? {W{1'b1}} : emem & exp_row();
			@(posedge core_clk_i);
			#1;
			check(flash_row_o, row);
			check({flash_prog_o, flash_erase_o, flash_config_space_o}, {~ctl[4], ctl[4], ctl[6]});
			@(posedge core_clk_i);
			cyc(1'b1, 1'b0, 4'h4, 8'h20);
			cyc(1'b0, 1'b0, 4'h4, 8'h00);
			for (int i = 0; i < N; i++) lat[i] = 14'h3FFF;
		end
		wait_idle();
		check(flash_row_data_o, exp_row());
		check(flash_array_model_inst.peek(row), emem);
		@(posedge core_clk_i);
		if (!ctl[5] || ctl[4]) rd(4'h4, {1'b1, ctl[6], 6'h04});
	endtask
	initial begin
		for (int i = 0; i < N; i++) lat[i] = 14'h3FFF;
		emem = '1;
		repeat (10) @(posedge core_clk_i);
		rst_i <= 1'b0;
		@(posedge core_clk_i);
		#1;
		check(flash_row_data_o, exp_row());
		@(posedge core_clk_i);
		rd(4'h4, 8'h80);
		rng = xs(rng);
		row = rng[10:0];
		cyc(1'b1, 1'b0, 4'h1, {1'b0, row[10:4]});
		cyc(1'b1, 1'b0, 4'h4, 8'h24);
		op(4'h0, 14'h0000, 8'h26);
		op(4'hF, 14'h3FFE, 8'h26);
		repeat (6) begin
			rng = xs(rng);
			op(rng[3:0], rng[17:4], 8'h26);
		end
		// Refused starts: enable off, doubled first key, doubled second key, broken sequence
		for (int i = 0; i < 4; i++) begin
			rng = xs(rng);
			cyc(1'b1, 1'b0, 4'h2, rng[7:0]);
			cyc(1'b1, 1'b0, 4'h4, (i == 0) ? 8'h20 : 8'h24);
			go((i == 2) ? 8'hAA : 8'h55, (i == 1) ? 8'h55 : 8'hAA, (i == 0) ? 8'h22 : 8'h26, i == 3);
			wait_idle();
			check(flash_row_data_o, exp_row());
			@(posedge core_clk_i);
			rd(4'h4, (i == 0) ? 8'hA8 : 8'hAC);
		end
		rng = xs(rng);
		op(rng[3:0], rng[13:0], 8'h06);
		op(4'h5, rng[17:4], 8'h46);
		op(4'h0, 14'h0000, 8'h16);
		op(4'h3, 14'h2A5A, 8'h26);
		rng = xs(rng);
		op(4'hC, rng[13:0], 8'h06);
		test_done();
	end
endmodule
